// ==== design/sdmc_ctrl.sv ====
// sdram memory controller with apb registers
`timescale 1ns/10ps
`default_nettype none
`include "sdmc_defs.svh"
// Behaviour
// - sixty four bit data path to memory
// - row and column timing set by software
// - four refresh styles, programmable interval
// - ram may shadow 640k to 1m
// - one module 16 to 128 mb extra
// - fixed 32 mb base array at 25mhz
// - all memory signals on rising edge
// - mode register set before any transfer
// - mode set on firmware request only
// - auto refresh only with banks idle
// - self refresh entry until exit command
// - decode base, video ram, video rom
// - top 64k routes to system rom unless shadow is on
module sdmc_ctrl #(
   parameter int BASE_MB = 32,
   parameter int RD_TIMEOUT = 16
) (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic req_valid_in,
   input wire sdmc_pkg::sdmc_req_t req_in,
   output logic req_ready_out,
   output logic [2:0] req_region_out,
   output logic rsp_valid_out,
   output logic [63:0] rsp_data_out,
   input wire logic rsp_ready_in,
   output sdmc_pkg::sdmc_mem_t mem_out,
   output logic [63:0] dq_out,
   output logic dq_oe_out,
   input wire logic [63:0] dq_in
);
   // ------------------------------------------------------------
   // reset and registers
   // ------------------------------------------------------------
   logic rst_s1_q, rst_n_q;
   logic [31:0] ctrl_q, timing_q, refrate_q, mode_q, size_q;
   logic init_done_q, selfref_q;
   logic [15:0] ref_cnt_q;
   logic ref_pend_q;
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end
   // ------------------------------------------------------------
   // apb slave, one wait free access phase
   // ------------------------------------------------------------
   wire apb_acc = psel_in & penable_in;
   wire apb_wr = apb_acc & pwrite_in;
   wire hit_ctrl = paddr_in == `SDMC_CTRL_OFF;
   wire hit_tim = paddr_in == `SDMC_TIMING_OFF;
   wire hit_rate = paddr_in == `SDMC_REFRATE_OFF;
   wire hit_mode = paddr_in == `SDMC_MODE_OFF;
   wire hit_stat = paddr_in == `SDMC_STATUS_OFF;
   wire hit_size = paddr_in == `SDMC_SIZE_OFF;
   wire hit_any = hit_ctrl | hit_tim | hit_rate | hit_mode | hit_stat
      | hit_size;
   wire [31:0] status_w = {28'h0, ref_pend_q, selfref_q, 1'b0,
      init_done_q};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_q : hit_tim ? timing_q :
      hit_rate ? refrate_q : hit_mode ? mode_q : hit_stat ? status_w :
      hit_size ? size_q : 32'h0;
   // init request bit self clears once mode set goes out
   logic init_go;
   always_ff @(posedge core_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ctrl_q <= 32'h0;
         timing_q <= `SDMC_TIMING_RST;
         refrate_q <= `SDMC_REFRATE_RST;
         mode_q <= `SDMC_MODE_RST;
         size_q <= `SDMC_SIZE_RST;
         prdata_out <= 32'h0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & ~hit_any;
         prdata_out <= rd_mux;
         if (apb_wr & hit_tim & pready_out)
            timing_q <= pwdata_in;
         if (apb_wr & hit_rate & pready_out)
            refrate_q <= pwdata_in;
         if (apb_wr & hit_mode & pready_out)
            mode_q <= pwdata_in;
         if (apb_wr & hit_size & pready_out)
            size_q <= {29'h0, pwdata_in[2:0]};
         if (apb_wr & hit_ctrl & pready_out)
            ctrl_q <= pwdata_in;
         else if (init_go)
            ctrl_q[`SDMC_CTRL_INIT_BIT] <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // address decode of the low megabyte
   // ------------------------------------------------------------
   sdmc_pkg::sdmc_req_t buf_q [2];
   logic [1:0] buf_v_q;
   logic wr_ptr_q, rd_ptr_q;
   wire [27:0] hd_addr = buf_q[rd_ptr_q].addr;
   wire low_mb = hd_addr[27:20] == 8'h0;
   wire [19:0] lo = hd_addr[19:0];
   wire shadow_en = ctrl_q[`SDMC_CTRL_SHADOW_BIT];
   wire [2:0] region_w = !low_mb ? 3'(sdmc_pkg::SDMC_RGN_EXT) :
      lo < `SDMC_BASE_END ? 3'(sdmc_pkg::SDMC_RGN_BASE) :
      shadow_en ? 3'(sdmc_pkg::SDMC_RGN_SHADOW) :
      lo < `SDMC_VRAM_END ? 3'(sdmc_pkg::SDMC_RGN_VRAM) :
      lo < `SDMC_VROM_END ? 3'(sdmc_pkg::SDMC_RGN_VROM) :
      lo >= `SDMC_SROM_START ? 3'(sdmc_pkg::SDMC_RGN_SROM) :
      3'(sdmc_pkg::SDMC_RGN_SHADOW);
   wire [7:0] mod_mb = size_q[2:0] == 3'h1 ? 8'h10 :
      size_q[2:0] == 3'h2 ? 8'h20 : size_q[2:0] == 3'h3 ? 8'h40 :
      size_q[2:0] == 3'h4 ? 8'h80 : 8'h0;
   wire [8:0] total_mb = 9'(BASE_MB) + {1'b0, mod_mb};
   wire in_range = {1'b0, hd_addr[27:20]} < total_mb;
   wire is_ram = region_w == 3'(sdmc_pkg::SDMC_RGN_BASE) |
      region_w == 3'(sdmc_pkg::SDMC_RGN_SHADOW) |
      region_w == 3'(sdmc_pkg::SDMC_RGN_EXT);
   // ------------------------------------------------------------
   // two entry request buffer
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ACT = 8'h02,
      ST_XFER = 8'h04,
      ST_WAIT = 8'h08,
      ST_PRE = 8'h10,
      ST_REF = 8'h20,
      ST_SELF = 8'h40,
      ST_MRS = 8'h80
   } sdmc_st_t;
   sdmc_st_t st_q, st_d;
   logic [7:0] cnt_q;
   logic take, pop;
   wire push = req_valid_in & req_ready_out;
   always_ff @(posedge core_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         buf_v_q <= 2'b00;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         req_ready_out <= 1'b0;
         buf_q[0] <= '0;
         buf_q[1] <= '0;
      end
      else
      begin
         if (push)
         begin
            buf_q[wr_ptr_q] <= req_in;
            buf_v_q[wr_ptr_q] <= 1'b1;
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop)
         begin
            buf_v_q[rd_ptr_q] <= 1'b0;
            rd_ptr_q <= ~rd_ptr_q;
         end
         req_ready_out <= ~(buf_v_q[0] & buf_v_q[1]) & ~push;
      end
   end
   // ------------------------------------------------------------
   // refresh interval counter
   // ------------------------------------------------------------
   // count down, raise request
   wire ref_done = st_q == ST_REF && cnt_q == 8'h0;
   always_ff @(posedge core_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ref_cnt_q <= 16'h0;
         ref_pend_q <= 1'b0;
      end
      else
      begin
         ref_cnt_q <= ref_cnt_q == 16'h0 ? refrate_q[15:0] :
            ref_cnt_q - 16'h1;
         // set wins over clear
         if (ref_cnt_q == 16'h0 && init_done_q)
            ref_pend_q <= 1'b1;
         else if (ref_done)
            ref_pend_q <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------
   wire [3:0] t_rcd = timing_q[3:0];
   wire [3:0] t_cl = timing_q[7:4];
   wire [3:0] t_rp = timing_q[11:8];
   wire head_v = buf_v_q[rd_ptr_q];
   wire [1:0] style = ctrl_q[`SDMC_CTRL_STYLE_LSB +: 2];
   wire sre_req = ctrl_q[`SDMC_CTRL_SRE_BIT];
   // mode set only on firmware request
   assign init_go = st_q == ST_IDLE && ctrl_q[`SDMC_CTRL_INIT_BIT];
   assign take = st_q == ST_IDLE && head_v && init_done_q &&
      !ref_pend_q && !sre_req && !init_go;
   wire rsp_stall = rsp_valid_out & ~rsp_ready_in;
   wire cnt_zero = cnt_q == 8'h0;
   always_comb
   begin
      st_d = st_q;
      pop = 1'b0;
      case (st_q)
         ST_IDLE:
         begin
            if (init_go)
               st_d = ST_MRS;
            else if (init_done_q && (ref_pend_q || sre_req))
               st_d = ST_PRE;
            else if (take && (!is_ram || !in_range))
               pop = 1'b1;
            else if (take)
               st_d = ST_ACT;
         end
         ST_ACT:
            if (cnt_zero)
               st_d = ST_XFER;
         ST_XFER:
            // writes also pass wait, or the precharge hides the write
            if (!rsp_stall)
               st_d = ST_WAIT;
         ST_WAIT:
            if (cnt_zero)
            begin
               st_d = ST_PRE;
               pop = 1'b1;
            end
         ST_PRE:
            if (cnt_zero)
            begin
               if (ref_pend_q)
                  st_d = ST_REF;
               else if (sre_req)
                  st_d = ST_SELF;
               else
                  st_d = ST_IDLE;
            end
         ST_REF:
            if (cnt_zero)
               st_d = ST_IDLE;
         ST_SELF:
            if (!sre_req && cnt_zero && !selfref_q)
               st_d = ST_IDLE;
         ST_MRS:
            st_d = ST_IDLE;
         default:
            st_d = ST_IDLE;
      endcase
   end
   // ------------------------------------------------------------
   // memory pins, all launched on the rising edge
   // ------------------------------------------------------------
   // every pin from a flop
   always_ff @(posedge core_clk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         st_q <= ST_IDLE;
         cnt_q <= 8'h0;
         init_done_q <= 1'b0;
         selfref_q <= 1'b0;
         mem_out <= '{cmd: 4'h7, addr: 13'h0, ba: 2'h0, cke: 1'b1};
         dq_out <= 64'h0;
         dq_oe_out <= 1'b0;
         rsp_valid_out <= 1'b0;
         rsp_data_out <= 64'h0;
         req_region_out <= 3'h0;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_zero ? 8'h0 : cnt_q - 8'h1;
         mem_out.cmd <= 4'(sdmc_pkg::SDMC_CMD_NOP);
         dq_oe_out <= 1'b0;
         req_region_out <= region_w;
         if (rsp_valid_out & rsp_ready_in)
            rsp_valid_out <= 1'b0;
         if (st_q == ST_IDLE && st_d == ST_MRS)
         begin
            mem_out.cmd <= 4'(sdmc_pkg::SDMC_CMD_MRS);
            mem_out.addr <= mode_q[12:0];
            mem_out.ba <= 2'h0;
         end
         if (st_q == ST_MRS)
            init_done_q <= 1'b1;
         if (st_q == ST_IDLE && st_d == ST_ACT)
         begin
            mem_out.cmd <= 4'(sdmc_pkg::SDMC_CMD_ACT);
            mem_out.addr <= hd_addr[24:12];
            mem_out.ba <= hd_addr[26:25];
            cnt_q <= {4'h0, t_rcd};
         end
         if (st_q == ST_XFER && st_d != ST_XFER)
         begin
            mem_out.addr <= {3'h0, hd_addr[11:3], 1'b0};
            if (buf_q[rd_ptr_q].we)
            begin
               mem_out.cmd <= 4'(sdmc_pkg::SDMC_CMD_WR);
               dq_out <= buf_q[rd_ptr_q].data;
               dq_oe_out <= 1'b1;
               cnt_q <= 8'h0;
            end
            else
            begin
               mem_out.cmd <= 4'(sdmc_pkg::SDMC_CMD_RD);
               cnt_q <= {4'h0, t_cl};
            end
         end
         if (st_q == ST_WAIT && cnt_zero && !buf_q[rd_ptr_q].we)
         begin
            rsp_valid_out <= 1'b1;
            rsp_data_out <= dq_in;
         end
         if ((st_d == ST_PRE) && (st_q != ST_PRE))
         begin
            mem_out.cmd <= 4'(sdmc_pkg::SDMC_CMD_PRE);
            mem_out.addr <= 13'h0400;
            cnt_q <= {4'h0, t_rp};
         end
         if (st_q == ST_PRE && st_d == ST_REF)
         begin
            mem_out.cmd <= 4'(sdmc_pkg::SDMC_CMD_REF);
            cnt_q <= 8'(`SDMC_TRFC_CYC) + {6'h0, style};
         end
         if (st_q == ST_PRE && st_d == ST_SELF)
         begin
            mem_out.cmd <= 4'(sdmc_pkg::SDMC_CMD_SRE);
            mem_out.cke <= 1'b0;
            selfref_q <= 1'b1;
         end
         if (st_q == ST_SELF && !sre_req && selfref_q)
         begin
            mem_out.cke <= 1'b1;
            selfref_q <= 1'b0;
            cnt_q <= 8'(`SDMC_TXSR_CYC);
         end
      end
   end
endmodule : sdmc_ctrl
`default_nettype wire

// ==== design/sdmc_defs.svh ====
// constants for the sdram memory controller
`ifndef SDMC_DEFS_SVH
`define SDMC_DEFS_SVH
// register byte offsets
`define SDMC_CTRL_OFF 12'h000
`define SDMC_TIMING_OFF 12'h004
`define SDMC_REFRATE_OFF 12'h008
`define SDMC_MODE_OFF 12'h00c
`define SDMC_STATUS_OFF 12'h010
`define SDMC_SIZE_OFF 12'h014
// control fields
`define SDMC_CTRL_INIT_BIT 0
`define SDMC_CTRL_SRE_BIT 1
`define SDMC_CTRL_SHADOW_BIT 2
`define SDMC_CTRL_STYLE_LSB 4
// reset values
`define SDMC_TIMING_RST 32'h0000_0222
`define SDMC_REFRATE_RST 32'h0000_0186
`define SDMC_MODE_RST 32'h0000_0033
`define SDMC_SIZE_RST 32'h0000_0000
// memory map, byte addresses in the low megabyte
`define SDMC_BASE_END 20'ha0000
`define SDMC_VRAM_END 20'hc0000
`define SDMC_VROM_END 20'hcc000
`define SDMC_SROM_START 20'hf0000
// timing: self refresh exit recovery in ns, clock period in ns
`define SDMC_TXSR_NS 80
`define SDMC_CLK_NS 40
`define SDMC_TXSR_CYC ((`SDMC_TXSR_NS + `SDMC_CLK_NS - 1) / `SDMC_CLK_NS)
`define SDMC_TRFC_CYC 4
`endif

// ==== design/sdmc_pkg.sv ====
// types for the sdram memory controller
package sdmc_pkg;
   typedef enum logic [3:0] {
      SDMC_CMD_NOP = 4'h7,
      SDMC_CMD_ACT = 4'h3,
      SDMC_CMD_RD = 4'h5,
      SDMC_CMD_WR = 4'h4,
      SDMC_CMD_PRE = 4'h2,
      SDMC_CMD_REF = 4'h1,
      SDMC_CMD_MRS = 4'h0,
      SDMC_CMD_SRE = 4'h9
   } sdmc_cmd_t;
   typedef enum logic [2:0] {
      SDMC_RGN_BASE = 3'h0,
      SDMC_RGN_VRAM = 3'h1,
      SDMC_RGN_VROM = 3'h2,
      SDMC_RGN_SHADOW = 3'h3,
      SDMC_RGN_SROM = 3'h4,
      SDMC_RGN_EXT = 3'h5
   } sdmc_rgn_t;
   typedef struct packed {
      logic we;
      logic [27:0] addr;
      logic [63:0] data;
   } sdmc_req_t;
   typedef struct packed {
      logic [3:0] cmd;
      logic [12:0] addr;
      logic [1:0] ba;
      logic cke;
   } sdmc_mem_t;
endpackage : sdmc_pkg

// ==== test/sdmc_ctrl_monitor.sv ====
// assertion checker on the sdram controller ports
`timescale 1ns/10ps
`default_nettype none
module sdmc_ctrl_monitor (
   input wire logic core_clk_in,
   input wire logic arst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic rsp_valid_out,
   input wire logic rsp_ready_in,
   input wire logic [63:0] rsp_data_out,
   input wire sdmc_pkg::sdmc_mem_t mem_out,
   input wire logic dq_oe_out
);
   // ---------------------------------------
   // command decode and bank tracking
   // ---------------------------------------
   logic [3:0] open_q;
   logic mrs_q;
   wire logic [3:0] c = mem_out.cmd;
   wire logic is_act = c == sdmc_pkg::SDMC_CMD_ACT;
   wire logic is_pre = c == sdmc_pkg::SDMC_CMD_PRE;
   wire logic is_ref = c == sdmc_pkg::SDMC_CMD_REF;
   wire logic is_nop = c == sdmc_pkg::SDMC_CMD_NOP;
   wire logic is_wr = c == sdmc_pkg::SDMC_CMD_WR;
   wire logic is_rd = c == sdmc_pkg::SDMC_CMD_RD;
   wire logic is_sre = c == sdmc_pkg::SDMC_CMD_SRE;
   wire logic [3:0] bank_bit = 4'h1 << mem_out.ba;
   // precharge with addr bit 10 closes every bank
   wire logic [3:0] open_d = is_pre ?
      (mem_out.addr[10] ? 4'h0 : open_q & ~bank_bit) :
      (is_act ? open_q | bank_bit : open_q);
   always_ff @(posedge core_clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         open_q <= 4'h0;
         mrs_q <= 1'b0;
      end
      else
      begin
         open_q <= open_d;
         mrs_q <= mrs_q | (c == sdmc_pkg::SDMC_CMD_MRS);
      end
   end
   // ---------------------------------------
   // assertions
   // ---------------------------------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!arst_n_in);
   a_ref_banks_idle: assert property (is_ref |-> open_q == 4'h0)
      else $error("refresh issued with a bank open");
   a_xfer_after_mrs: assert property ((is_act | is_rd | is_wr) |-> mrs_q)
      else $error("transfer before mode register set");
   a_write_drives_dq: assert property (dq_oe_out == is_wr)
      else $error("data drive not tied to write command");
   a_ref_hold_off: assert property (is_ref |=> is_nop [*3])
      else $error("command too soon after refresh");
   a_sre_cke_low: assert property (is_sre |-> ##[0:1] !mem_out.cke)
      else $error("clock enable not lowered for self refresh");
   a_exit_recovery: assert property ($rose(mem_out.cke) |-> is_nop [*2])
      else $error("command inside self refresh exit time");
   a_rsp_held: assert property (rsp_valid_out && !rsp_ready_in |=>
      rsp_valid_out && $stable(rsp_data_out))
      else $error("stalled read response changed");
   a_apb_answer: assert property (psel_in && !penable_in |=>
      pready_out ##1 !pready_out)
      else $error("register access not answered in one cycle");
endmodule : sdmc_ctrl_monitor
bind sdmc_ctrl sdmc_ctrl_monitor u_mon (.core_clk_in, .arst_n_in, .psel_in,
   .penable_in, .pready_out, .rsp_valid_out, .rsp_ready_in, .rsp_data_out,
   .mem_out, .dq_oe_out);
`default_nettype wire

// ==== test/sdmc_sdram_model.sv ====
// behavioural sdram array facing the controller
`timescale 1ns/10ps
`default_nettype none
module sdmc_sdram_model (
   input wire logic clk_in,
   input wire sdmc_pkg::sdmc_mem_t mem_in,
   input wire logic [63:0] dq_in,
   input wire logic dq_oe_in,
   output logic [63:0] dq_out
);
   logic [63:0] store [logic [27:0]];
   logic [12:0] row [4];
   logic [63:0] sd [8];
   logic [7:0] sv = 8'h0;
   logic [2:0] cl = 3'h3;
   logic [3:0] cnt = 4'h0;
   logic in_sr = 1'b0;
   wire logic [27:0] key = {mem_in.ba, row[mem_in.ba], mem_in.addr};
   // everything taken at the rising edge
   always @(posedge clk_in)
   begin
      cnt <= cnt + 4'h1;
      sv = sv >> 1;
      for (int i = 0; i < 7; i++)
         sd[i] = sd[i + 1];
      // self refresh until clock enable returns
      if (mem_in.cke)
         in_sr = 1'b0;
      case (mem_in.cmd)
         sdmc_pkg::SDMC_CMD_MRS: cl = mem_in.addr[6:4];
         sdmc_pkg::SDMC_CMD_ACT: row[mem_in.ba] = mem_in.addr;
         sdmc_pkg::SDMC_CMD_WR: if (dq_oe_in) store[key] = dq_in;
         sdmc_pkg::SDMC_CMD_SRE: in_sr = 1'b1;
         // first word after the programmed latency
         sdmc_pkg::SDMC_CMD_RD:
         begin
            sd[cl - 3'h1] = store.exists(key) ? store[key] : 64'h0;
            sv[cl - 3'h1] = 1'b1;
         end
         default: ;
      endcase
      // refresh is internal, bus released meanwhile
      // released bus toggles so a stale value never looks valid
      dq_out <= (sv[0] && !in_sr) ? sd[0] : {16{cnt}};
   end
endmodule : sdmc_sdram_model
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the sdram controller
`timescale 1ns/10ps
`default_nettype none
`include "sdmc_defs.svh"
module tb_top;
   logic core_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h0;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic req_valid_in = 1'b0;
   sdmc_pkg::sdmc_req_t req_in = '0;
   logic req_ready_out;
   logic [2:0] req_region_out;
   logic rsp_valid_out;
   logic [63:0] rsp_data_out;
   logic rsp_ready_in = 1'b0;
   sdmc_pkg::sdmc_mem_t mem_out;
   logic [63:0] dq_out;
   logic dq_oe_out;
   logic [63:0] dq_in;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [63:0] d1 = 64'h0123_4567_89ab_cdef;
   sdmc_ctrl u_dut (.core_clk_in, .arst_n_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
      .pslverr_out, .req_valid_in, .req_in, .req_ready_out, .req_region_out,
      .rsp_valid_out, .rsp_data_out, .rsp_ready_in, .mem_out, .dq_out,
      .dq_oe_out, .dq_in);
   sdmc_sdram_model u_mem (.clk_in(core_clk_in), .mem_in(mem_out),
      .dq_in(dq_out), .dq_oe_in(dq_oe_out), .dq_out(dq_in));
   always #20 core_clk_in = ~core_clk_in;
   // ---------------------------------------
   // shared tasks
   // ---------------------------------------
   task automatic conclude();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   always @(posedge core_clk_in)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
      n_compared++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge core_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      do
         @(posedge core_clk_in);
      while (pready_out !== 1'b1);
      r = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic poll(input int b, input logic v, output logic [31:0] r);
      logic e;
      int k;
      k = 0;
      do
      begin
         apb(1'b0, `SDMC_STATUS_OFF, 32'h0, r, e);
         k++;
      end
      while (r[b] !== v && k < 100);
   endtask : poll
   task automatic push(input logic w, input logic [27:0] a,
      input logic [63:0] d, output logic ok);
      int k;
      @(posedge core_clk_in);
      req_valid_in <= 1'b1;
      req_in <= '{we: w, addr: a, data: d};
      k = 0;
      do
      begin
         @(posedge core_clk_in);
         k++;
      end
      while (req_ready_out !== 1'b1 && k < 60);
      ok = req_ready_out === 1'b1;
      req_valid_in <= 1'b0;
   endtask : push
   task automatic pull_chk(input logic [63:0] e);
      @(posedge core_clk_in);
      rsp_ready_in <= 1'b1;
      do
         @(posedge core_clk_in);
      while (rsp_valid_out !== 1'b1);
      chk("read data", e, rsp_data_out);
      rsp_ready_in <= 1'b0;
   endtask : pull_chk
   task automatic do_reset();
      arst_n_in <= 1'b0;
      repeat (10) @(posedge core_clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
   endtask : do_reset
   // ---------------------------------------
   // scenarios
   // ---------------------------------------
   task automatic t_decode();
      logic [27:0] da[6] = '{28'h9fff8, 28'ha0000, 28'hcbff8, 28'hf0000,
         28'hc0000, 28'h100000};
      logic [2:0] dr[6] = '{sdmc_pkg::SDMC_RGN_BASE, sdmc_pkg::SDMC_RGN_VRAM,
         sdmc_pkg::SDMC_RGN_VROM, sdmc_pkg::SDMC_RGN_SROM,
         sdmc_pkg::SDMC_RGN_SHADOW, sdmc_pkg::SDMC_RGN_EXT};
      logic ok;
      for (int i = 0; i < 6; i++)
      begin
         do_reset();
         if (i == 4)
            wr(`SDMC_CTRL_OFF, 32'h4);
         push(1'b0, da[i], 64'h0, ok);
         repeat (3) @(posedge core_clk_in);
         chk("region", dr[i], req_region_out);
      end
      // nothing leaves the buffer before init
      push(1'b0, 28'h0, 64'h0, ok);
      chk("second entry", 1'b1, ok);
      push(1'b0, 28'h8, 64'h0, ok);
      chk("full refuses", 1'b0, ok);
   endtask : t_decode
   task automatic t_regs();
      logic [11:0] oa[5] = '{`SDMC_TIMING_OFF, `SDMC_REFRATE_OFF,
         `SDMC_MODE_OFF, `SDMC_SIZE_OFF, 12'h018};
      logic [31:0] ov[5] = '{`SDMC_TIMING_RST, `SDMC_REFRATE_RST,
         `SDMC_MODE_RST, `SDMC_SIZE_RST, 32'h0};
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, oa[i], 32'h0, r, e);
         chk("reset value", ov[i], r);
         chk("slave error", i == 4, e);
      end
      // cas latency 3 matches the mode word
      wr(`SDMC_TIMING_OFF, 32'h232);
      apb(1'b0, `SDMC_TIMING_OFF, 32'h0, r, e);
      chk("timing", 32'h232, r);
   endtask : t_regs
   task automatic t_init();
      logic [31:0] r;
      poll(0, 1'b1, r);
      chk("init idle", 1'b0, r[0]);
      wr(`SDMC_CTRL_OFF, 32'h1);
      poll(0, 1'b1, r);
      chk("init done", 1'b1, r[0]);
   endtask : t_init
   task automatic t_data();
      logic ok;
      push(1'b1, 28'h100, d1, ok);
      push(1'b1, 28'h10208, ~d1, ok);
      push(1'b0, 28'h100, 64'h0, ok);
      push(1'b0, 28'h10208, 64'h0, ok);
      repeat (8) @(posedge core_clk_in);
      pull_chk(d1);
      pull_chk(~d1);
   endtask : t_data
   task automatic t_refresh();
      logic ok;
      int n;
      wr(`SDMC_REFRATE_OFF, 32'h20);
      for (int s = 0; s < 4; s++)
      begin
         wr(`SDMC_CTRL_OFF, s << `SDMC_CTRL_STYLE_LSB);
         n = 0;
         repeat (320)
         begin
            @(posedge core_clk_in);
            if (mem_out.cmd === sdmc_pkg::SDMC_CMD_REF)
               n++;
         end
         chk("refresh count", 1'b1, n >= 5 && n <= 10);
      end
      push(1'b0, 28'h100, 64'h0, ok);
      pull_chk(d1);
   endtask : t_refresh
   task automatic t_selfref();
      logic [31:0] r;
      logic ok;
      wr(`SDMC_CTRL_OFF, 32'h2);
      poll(2, 1'b1, r);
      chk("in self refresh", 1'b1, r[2]);
      chk("cke low", 1'b0, mem_out.cke);
      wr(`SDMC_CTRL_OFF, 32'h0);
      poll(2, 1'b0, r);
      chk("out of self refresh", 1'b0, r[2]);
      chk("cke high", 1'b1, mem_out.cke);
      push(1'b0, 28'h10208, 64'h0, ok);
      pull_chk(~d1);
   endtask : t_selfref
   initial
   begin
      t_decode();
      do_reset();
      t_regs();
      t_init();
      t_data();
      t_refresh();
      t_selfref();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
